// >>> logic/vipcfg_top.sv
// video input port configuration register and port control
//
// Summary of operation
// - clock source bits 23-22, default graphics clock
// - registers answer only while a clock runs
// - drive clock pin only for display-timing source
// - writing 01 selects external clock, restarts timeout
// - about 16 cycles without clock, revert to graphics
// - status bit 9 reports external clock present
// - bit 21 picks first capture buffer
// - bit 20 switches the pixel decimator
// - bit 19 makes displayed buffer follow capture
// - bits 18-16 choose stream decoding format
// - format 0 recovers timing from embedded codes
// - multiplexed format generates or locks timing
// - timing generator on for formats 0-3 only
// - bit 15 reserved, reads zero, mask it
// - threshold is bits 13-12 over bits 3-1
// - bits 11-10 set frame skip over field pairs
// - decimator halves pixels, else pass through
// - code 10 selects display clock, 11 reserved
// - start bit 0 fills buffer 0 first
`timescale 1ns/100ps
module vipcfg_top
	import vipcfg_pkg::*;
#(
	parameter int TIMEOUT    = TIMEOUT_CYCLES,
	parameter int FIFO_LVL_W = 6
) (
	// clock, reset, enable
	input  wire logic                 core_clk_in,
	input  wire logic                 rst_n_in,
	input  wire logic                 ce_in,
	// configuration register port
	input  wire logic                 cfg_wr_in,
	input  wire logic                 cfg_rd_in,
	input  wire logic                 stat_rd_in,
	input  wire logic [31:0]          cfg_wdata_in,
	output logic      [31:0]          cfg_rdata_out,
	output logic                      cfg_ack_out,
	// clock sources
	input  wire logic                 disp_clk_running_in,
	input  wire logic                 disp_timing_gen_in,
	// video port clock pin
	input  wire logic                 video_port_clock_pin_in,
	output logic                      video_port_clock_pin_out,
	output logic                      video_port_clock_pin_oe_out,
	// field and frame events
	input  wire logic                 field_odd_in,
	input  wire logic                 frame_end_in,
	input  wire logic                 buffer_done_in,
	// embedded code and external timing
	input  wire logic                 sav_seen_in,
	input  wire logic                 eav_seen_in,
	input  wire logic                 ext_timing_lock_in,
	// stream
	input  vipcfg_pkg::vipcfg_pix_s   pix_in,
	output vipcfg_pkg::vipcfg_pix_s   pix_out,
	// capture fifo and memory request
	input  wire logic [FIFO_LVL_W-1:0] fifo_level_in,
	output logic                      mem_req_out,
	// capture control
	output logic                      fill_buf_out,
	output logic                      disp_buf_out,
	output logic                      disp_update_out,
	output logic                      timing_gen_en_out,
	output logic                      timing_embedded_out,
	output logic                      timing_ext_lock_out,
	output logic                      line_start_out,
	output logic                      capture_frame_out,
	output logic      [2:0]           fmt_out
);
	vipcfg_cfg_s cfg_q;
	logic [31:0] rdata_q;
	logic        ack_q;
	logic        fill_q;
	logic        disp_q;
	logic        disp_upd_q;
	logic [SKIP_W-1:0] skip_cnt_q;
	logic        cap_q;
	logic        req_q;
	logic        line_q;
	logic [1:0]  disp_sync_q;
	logic        fodd_q;

	wire         present;
	wire         expired;
	wire         wr_ext;
	wire         clk_running;
	wire [31:0]  cfg_word;
	wire [4:0]   thresh_w;
	wire [1:0]   src_w;
	wire         field_pair_end;
	wire         skip_hit;
	wire         tg_enable;

	// a write that picks the external clock restarts qualification
	assign src_w  = cfg_wdata_in[CLKSRC_HI:CLKSRC_LO];
	assign wr_ext = cfg_wr_in & (src_w == SRC_EXT);
	assign thresh_w = {cfg_wdata_in[THR_HI_HI:THR_HI_LO],
	                   cfg_wdata_in[THR_LO_HI:THR_LO_LO]};

	vipcfg_clkdet #(
		.TIMEOUT (TIMEOUT)
	) u_clkdet (
		.core_clk_in (core_clk_in),
		.rst_n_in    (rst_n_in),
		.ce_in       (ce_in),
		.restart_in  (wr_ext),
		.qualify_in  (cfg_q.clk_src == SRC_EXT),
		.video_port_clock_pin_in (video_port_clock_pin_in),
		.present_out (present),
		.expired_out (expired)
	);

	// graphics clock always runs; the other two need their source alive
	assign clk_running = (cfg_q.clk_src == SRC_GFX) |
	                     ((cfg_q.clk_src == SRC_EXT) & present) |
	                     ((cfg_q.clk_src == SRC_DISP) & disp_sync_q[1]);

	// reserved bit 15 reads zero; software masks it anyway
	assign cfg_word = {8'h0,
	                   cfg_q.clk_src,
	                   cfg_q.start_buf,
	                   cfg_q.halve,
	                   cfg_q.follow,
	                   cfg_q.fmt,
	                   1'b0,
	                   cfg_q.flip,
	                   cfg_q.thresh[4:3],
	                   cfg_q.skip,
	                   6'h0,
	                   cfg_q.thresh[2:0],
	                   1'b0};

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			cfg_q       <= CFG_RESET[$bits(vipcfg_cfg_s)-1:0];
			rdata_q     <= 32'h0;
			ack_q       <= 1'b0;
			disp_sync_q <= 2'h0;
		end else if (ce_in) begin
			disp_sync_q <= {disp_sync_q[0], disp_clk_running_in};
			ack_q       <= (cfg_wr_in | cfg_rd_in | stat_rd_in) &
			               clk_running;
			if (cfg_wr_in && clk_running) begin
				cfg_q.clk_src   <= src_w;
				cfg_q.start_buf <= cfg_wdata_in[START_BIT];
				cfg_q.halve     <= cfg_wdata_in[HALVE_BIT];
				cfg_q.follow    <= cfg_wdata_in[FOLLOW_BIT];
				cfg_q.fmt       <= cfg_wdata_in[FMT_HI:FMT_LO];
				cfg_q.flip      <= cfg_wdata_in[FLIP_BIT];
				cfg_q.thresh    <= thresh_w;
				cfg_q.skip      <= cfg_wdata_in[SKIP_HI:SKIP_LO];
			end else if (expired) begin
				cfg_q.clk_src <= SRC_GFX;
			end
			if (cfg_rd_in && clk_running)
				rdata_q <= cfg_word;
			else if (stat_rd_in && clk_running)
				rdata_q <= 32'(present) << PRESENT_BIT;
		end
	end

	// pin drives only when display clock feeds it and the display
	// timing controller generates the port timing
	assign video_port_clock_pin_oe_out = (cfg_q.clk_src == SRC_DISP) &
	                         disp_timing_gen_in;
	assign video_port_clock_pin_out    = video_port_clock_pin_oe_out & disp_sync_q[1];

	// timing generator enable and mode
	assign tg_enable = cfg_q.fmt < FMT_TG_LIMIT;
	assign timing_gen_en_out   = tg_enable;
	assign timing_embedded_out = (cfg_q.fmt == FMT_VIP);
	// multiplexed mode locks to external timing when offered
	assign timing_ext_lock_out = (cfg_q.fmt == FMT_MUX601) &
	                             ext_timing_lock_in;
	assign fmt_out = cfg_q.fmt;

	// a frame period is an odd field then an even one
	assign field_pair_end = frame_end_in & ~field_odd_in;
	assign skip_hit       = (skip_cnt_q == cfg_q.skip);

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			fill_q     <= 1'b0;
			disp_q     <= 1'b0;
			disp_upd_q <= 1'b0;
			skip_cnt_q <= '0;
			cap_q      <= 1'b1;
			req_q      <= 1'b0;
			line_q     <= 1'b0;
			fodd_q     <= 1'b0;
		end else if (ce_in) begin
			fodd_q     <= field_odd_in;
			disp_upd_q <= 1'b0;
			// embedded codes mark lines only in the code-based format
			line_q <= timing_embedded_out & (sav_seen_in | eav_seen_in);
			if (cfg_wr_in && clk_running)
				fill_q <= cfg_wdata_in[START_BIT];
			else if (buffer_done_in) begin
				fill_q <= ~fill_q;
				if (cfg_q.follow) begin
					disp_q     <= fill_q;
					disp_upd_q <= 1'b1;
				end
			end
			if (field_pair_end) begin
				if (skip_hit) begin
					skip_cnt_q <= '0;
					cap_q      <= 1'b1;
				end else begin
					skip_cnt_q <= skip_cnt_q + SKIP_W'(1);
					cap_q      <= 1'b0;
				end
			end
			// threshold counts 64-bit words held
			req_q <= (cfg_q.thresh != 5'h0) &
			         (fifo_level_in >= FIFO_LVL_W'(cfg_q.thresh));
		end
	end

	vipcfg_pixpath u_pix (
		.core_clk_in (core_clk_in),
		.rst_n_in    (rst_n_in),
		.ce_in       (ce_in),
		.halve_in    (cfg_q.halve),
		.flip_in     (cfg_q.flip),
		.enable_in   (cap_q & clk_running),
		.pix_in      (pix_in),
		.pix_out     (pix_out)
	);

	assign cfg_rdata_out     = rdata_q;
	assign cfg_ack_out       = ack_q;
	assign fill_buf_out      = fill_q;
	assign disp_buf_out      = disp_q;
	assign disp_update_out   = disp_upd_q;
	assign mem_req_out       = req_q;
	assign line_start_out    = line_q;
	assign capture_frame_out = cap_q;
endmodule

// >>> common/vipcfg_pkg.sv
// package for the video input port configuration block
package vipcfg_pkg;
	// register bit positions
	localparam int CLKSRC_HI   = 23;
	localparam int CLKSRC_LO   = 22;
	localparam int START_BIT   = 21;
	localparam int HALVE_BIT   = 20;
	localparam int FOLLOW_BIT  = 19;
	localparam int FMT_HI      = 18;
	localparam int FMT_LO      = 16;
	localparam int RSV_BIT     = 15;
	localparam int FLIP_BIT    = 14;
	localparam int THR_HI_HI   = 13;
	localparam int THR_HI_LO   = 12;
	localparam int SKIP_HI     = 11;
	localparam int SKIP_LO     = 10;
	localparam int THR_LO_HI   = 3;
	localparam int THR_LO_LO   = 1;
	localparam int PRESENT_BIT = 9;
	// clock source codes
	localparam logic [1:0] SRC_GFX  = 2'h0;
	localparam logic [1:0] SRC_EXT  = 2'h1;
	localparam logic [1:0] SRC_DISP = 2'h2;
	// format codes at or above this disable the timing generator
	localparam logic [2:0] FMT_TG_LIMIT   = 3'h4;
	localparam logic [2:0] FMT_VIP        = 3'h0;
	localparam logic [2:0] FMT_MUX601     = 3'h3;
	// reset value of the configuration word
	localparam logic [31:0] CFG_RESET     = 32'h0;
	// time-out for clock presence, in graphics clock periods
	localparam int TIMEOUT_GRAPHICS_CLOCK   = 16;
	localparam int TIMEOUT_CYCLES = TIMEOUT_GRAPHICS_CLOCK;
	localparam int TO_W           = 5;
	// frame skip counter width
	localparam int SKIP_W = 2;

	typedef struct packed {
		logic [1:0] clk_src;
		logic       start_buf;
		logic       halve;
		logic       follow;
		logic [2:0] fmt;
		logic       flip;
		logic [4:0] thresh;
		logic [1:0] skip;
	} vipcfg_cfg_s;

	typedef struct packed {
		logic        valid;
		logic [15:0] data;
	} vipcfg_pix_s;
endpackage

// >>> logic/vipcfg_clkdet.sv
// external video clock presence detector and time-out
`timescale 1ns/100ps
module vipcfg_clkdet
	import vipcfg_pkg::*;
#(
	parameter int TIMEOUT = TIMEOUT_CYCLES
) (
	// clock and reset
	input  wire logic core_clk_in,
	input  wire logic rst_n_in,
	input  wire logic ce_in,
	// control
	input  wire logic restart_in,
	input  wire logic qualify_in,
	input  wire logic video_port_clock_pin_in,
	// status
	output logic      present_out,
	output logic      expired_out
);
	logic [2:0]      sync_q;
	logic [TO_W-1:0] cnt_q;
	logic            present_q;
	logic            expired_q;
	wire             edge_seen;

	// second stage feeds the edge detector, first stage is left alone
	assign edge_seen = sync_q[1] & ~sync_q[2];

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			sync_q    <= 3'h0;
			cnt_q     <= '0;
			present_q <= 1'b0;
			expired_q <= 1'b0;
		end else if (ce_in) begin
			sync_q    <= {sync_q[1:0], video_port_clock_pin_in};
			expired_q <= 1'b0;
			if (restart_in) begin
				cnt_q     <= '0;
				present_q <= 1'b0;
			end else if (qualify_in && edge_seen) begin
				cnt_q     <= '0;
				present_q <= 1'b1;
			end else if (qualify_in) begin
				if (cnt_q == TO_W'(TIMEOUT - 1)) begin
					cnt_q     <= '0;
					present_q <= 1'b0;
					expired_q <= 1'b1;
				end else begin
					cnt_q <= cnt_q + TO_W'(1);
				end
			end else begin
				present_q <= 1'b0;
			end
		end
	end

	assign present_out = present_q;
	assign expired_out = expired_q;
endmodule

// >>> logic/vipcfg_pixpath.sv
// pixel path: decimation and byte order
`timescale 1ns/100ps
module vipcfg_pixpath
	import vipcfg_pkg::*;
(
	// clock and reset
	input  wire logic core_clk_in,
	input  wire logic rst_n_in,
	input  wire logic ce_in,
	// control
	input  wire logic halve_in,
	input  wire logic flip_in,
	input  wire logic enable_in,
	// stream
	input  vipcfg_pkg::vipcfg_pix_s pix_in,
	output vipcfg_pkg::vipcfg_pix_s pix_out
);
	logic        phase_q;
	vipcfg_pix_s out_q;
	wire         keep;
	wire  [15:0] swapped;

	assign keep    = ~halve_in | ~phase_q;
	assign swapped = flip_in ? {pix_in.data[7:0], pix_in.data[15:8]}
	                         : pix_in.data;

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			phase_q <= 1'b0;
			out_q   <= '0;
		end else if (ce_in) begin
			if (pix_in.valid && enable_in)
				phase_q <= halve_in ? ~phase_q : 1'b0;
			out_q.valid <= pix_in.valid & enable_in & keep;
			out_q.data  <= swapped;
		end
	end

	assign pix_out = out_q;
endmodule

// >>> tb/vipcfg_top_assertions.sv
// port-level assertions for the video input port configuration block
`timescale 1ns/100ps
module vipcfg_top_assertions
	import vipcfg_pkg::*;
#(
	parameter int FIFO_LVL_W = 6
) (
	// clock and register port
	input  wire logic                  core_clk_in,
	input  wire logic                  rst_n_in,
	input  wire logic                  cfg_wr_in,
	input  wire logic                  cfg_rd_in,
	input  wire logic                  stat_rd_in,
	input  wire logic [31:0]           cfg_wdata_in,
	input  wire logic                  cfg_ack_out,
	// pin, fifo and control
	input  wire logic                  disp_timing_gen_in,
	input  wire logic                  video_port_clock_pin_oe_out,
	input  wire logic [FIFO_LVL_W-1:0] fifo_level_in,
	input  wire logic                  mem_req_out,
	input  wire logic                  fill_buf_out,
	input  wire logic                  timing_gen_en_out,
	input  wire logic [2:0]            fmt_out,
	// stream
	input  vipcfg_pkg::vipcfg_pix_s    pix_in,
	input  vipcfg_pkg::vipcfg_pix_s    pix_out
);
	// shadow of the last accepted write, one cycle behind the register
	logic [31:0] wd_q;
	logic [31:0] sh_q;
	logic        wr_q;
	logic [4:0]  thr_w;
	assign thr_w = {sh_q[13:12], sh_q[3:1]};
	always_ff @(posedge core_clk_in) begin
		wd_q <= cfg_wdata_in;
		wr_q <= cfg_wr_in;
		if (!rst_n_in)
			sh_q <= 32'h0;
		else if (cfg_ack_out && wr_q)
			sh_q <= wd_q;
	end
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);
	a_ack_has_cause: assert property (cfg_ack_out
		|-> $past(cfg_wr_in || cfg_rd_in || stat_rd_in))
		else $error("ack without a request");
	a_tg_by_format: assert property (
		timing_gen_en_out == (fmt_out < 3'h4))
		else $error("timing generator enable wrong");
	a_fmt_tracks_write: assert property (cfg_ack_out && wr_q
		|=> fmt_out == sh_q[18:16])
		else $error("format does not follow write");
	a_oe_needs_disp: assert property (video_port_clock_pin_oe_out
		|-> (sh_q[23:22] == 2'h2 || cfg_ack_out) && (disp_timing_gen_in
		|| $past(disp_timing_gen_in) || $past(disp_timing_gen_in, 2)))
		else $error("clock pin driven without display source");
	a_req_threshold: assert property (
		thr_w != 5'h0 && $stable(thr_w) && !cfg_ack_out |=> mem_req_out
		== ($past(fifo_level_in) >= FIFO_LVL_W'($past(thr_w))))
		else $error("memory request disagrees with threshold");
	a_pix_cause: assert property (pix_out.valid |-> $past(pix_in.valid))
		else $error("pixel out without pixel in");
	a_flip_bytes: assert property (pix_out.valid |-> pix_out.data ==
		(sh_q[14] ? {$past(pix_in.data[7:0]), $past(pix_in.data[15:8])}
		: $past(pix_in.data)))
		else $error("byte order wrong");
	a_halve_gap: assert property (pix_out.valid && sh_q[20]
		|=> !pix_out.valid)
		else $error("decimator passed adjacent pixels");
	a_fill_start: assert property (cfg_ack_out && wr_q
		|=> fill_buf_out == sh_q[21])
		else $error("first buffer not taken from start bit");
endmodule
bind vipcfg_top vipcfg_top_assertions #(.FIFO_LVL_W(FIFO_LVL_W)) u_chk (
	.core_clk_in, .rst_n_in, .cfg_wr_in, .cfg_rd_in, .stat_rd_in,
	.cfg_wdata_in, .cfg_ack_out, .disp_timing_gen_in, .video_port_clock_pin_oe_out,
	.fifo_level_in, .mem_req_out, .fill_buf_out, .timing_gen_en_out,
	.fmt_out, .pix_in, .pix_out);

// >>> tb/vipcfg_vsrc.sv
// external video source model driving the port clock pin
`timescale 1ns/100ps
module vipcfg_vsrc (
	// control
	input  wire logic en_in,
	// port clock
	output logic      video_port_clock_out
);
	// stands low when off so a stale level never looks like a clock
	initial begin
		video_port_clock_out = 1'b0;
		forever begin
			#32;
			video_port_clock_out = en_in ? ~video_port_clock_out : 1'b0;
		end
	end
endmodule

// >>> tb/test_video_input_port_config.sv
// self-checking bench for the video input port configuration block
`timescale 1ns/100ps
module test_video_input_port_config;
	import vipcfg_pkg::*;
	localparam int TO = 24;
	logic core_clk_in, rst_n_in, ce_in, cfg_wr_in, cfg_rd_in, stat_rd_in;
	logic disp_clk_running_in, disp_timing_gen_in, video_port_clock_pin_in, ven;
	logic field_odd_in, frame_end_in, buffer_done_in, sav_seen_in;
	logic eav_seen_in, ext_timing_lock_in, cfg_ack_out, video_port_clock_pin_oe_out;
	logic mem_req_out, fill_buf_out, timing_gen_en_out, capture_frame_out;
	logic emb, xlock, lstart, dbuf, vpo;
	logic [31:0] cfg_wdata_in, cfg_rdata_out, q;
	logic [5:0]  fifo_level_in;
	logic [2:0]  fmt_out;
	vipcfg_pix_s pix_in, pix_out;
	int          bad_count, tests_run, i, n, m;
	bit          got;
	vipcfg_vsrc u_src (.en_in(ven), .video_port_clock_out(video_port_clock_pin_in));
	vipcfg_top #(.TIMEOUT(TO)) DUT (.core_clk_in, .rst_n_in, .ce_in,
		.cfg_wr_in, .cfg_rd_in, .stat_rd_in, .cfg_wdata_in, .cfg_rdata_out,
		.cfg_ack_out, .disp_clk_running_in, .disp_timing_gen_in,
		.video_port_clock_pin_in, .video_port_clock_pin_out(vpo), .video_port_clock_pin_oe_out, .field_odd_in,
		.frame_end_in, .buffer_done_in, .sav_seen_in, .eav_seen_in,
		.ext_timing_lock_in, .pix_in, .pix_out, .fifo_level_in,
		.mem_req_out, .fill_buf_out, .disp_buf_out(dbuf),
		.disp_update_out(), .timing_gen_en_out,
		.timing_embedded_out(emb), .timing_ext_lock_out(xlock),
		.line_start_out(lstart), .capture_frame_out, .fmt_out);
	initial begin
		core_clk_in = 1'b0;
		forever #2 core_clk_in = ~core_clk_in;
	end
	task automatic conclude();
		$display("compares %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, e);
		tests_run++;
		if (s !== e) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic tick(input int c);
		repeat (c) @(posedge core_clk_in);
	endtask
	// one strobe pulse, then a bounded wait for the acknowledge
	task automatic acc(input int k, input logic [31:0] d);
		int j;
		@(posedge core_clk_in);
		cfg_wr_in <= (k == 0);
		cfg_rd_in <= (k == 1);
		stat_rd_in <= (k == 2);
		cfg_wdata_in <= d;
		@(posedge core_clk_in);
		{cfg_wr_in, cfg_rd_in, stat_rd_in} <= 3'h0;
		got = 0;
		// look mid-cycle so the registered answer is settled
		for (j = 0; j < 4 && !got; j++) begin
			@(negedge core_clk_in);
			got = (cfg_ack_out === 1'b1);
			q = cfg_rdata_out;
		end
		@(posedge core_clk_in);
	endtask
	task automatic op(input int k, input logic [31:0] d);
		acc(k, d);
		chk("ack", 32'(got), 32'h1);
		if (!got)
			conclude();
	endtask
	initial begin
		#200000;
		bad_count++;
		conclude();
	end
	initial begin
		{rst_n_in, cfg_wr_in, cfg_rd_in, stat_rd_in, ven} = 5'h0;
		{disp_clk_running_in, disp_timing_gen_in, field_odd_in} = 3'h0;
		{frame_end_in, buffer_done_in, sav_seen_in, eav_seen_in} = 4'h0;
		ext_timing_lock_in = 1'b0;
		ce_in = 1'b1;
		cfg_wdata_in = 32'h0;
		fifo_level_in = 6'h0;
		pix_in = '0;
		tick(8);
		rst_n_in <= 1'b1;
		op(1, 0);
		chk("cfg reset", q, 32'h0);
		op(0, 32'hff3f_fffe);
		op(1, 0);
		chk("cfg fields", q, 32'h003f_7c0e);
		for (n = 0; n < 8; n++) begin
			op(0, 32'(n) << 16);
			chk("tgen", 32'(timing_gen_en_out), 32'(n < 4));
			chk("fmt", 32'(fmt_out), n);
			chk("embedded", 32'(emb), 32'(n == 0));
		end
		ext_timing_lock_in <= 1'b1;
		op(0, 32'h0003_0000);
		chk("lock", 32'(xlock), 32'h1);
		ext_timing_lock_in <= 1'b0;
		for (n = 0; n < 2; n++) begin
			op(0, 32'(n) << 21);
			tick(1);
			chk("fill", 32'(fill_buf_out), n);
		end
		op(0, 32'h0000_2006);
		fifo_level_in <= 6'h12;
		tick(3);
		chk("req low", 32'(mem_req_out), 32'h0);
		fifo_level_in <= 6'h13;
		tick(3);
		chk("req high", 32'(mem_req_out), 32'h1);
		fifo_level_in <= 6'h0;
		op(0, 32'h0000_4000);
		pix_in <= '{1'b1, 16'h1234};
		tick(1);
		pix_in <= '0;
		#1;
		chk("flip", 32'(pix_out), 32'h0001_3412);
		op(0, 32'h0010_0000);
		n = 0;
		pix_in <= '{1'b1, 16'h00a5};
		for (i = 0; i < 7; i++) begin
			@(posedge core_clk_in);
			if (i == 3)
				pix_in <= '0;
			n += (pix_out.valid === 1'b1);
		end
		chk("halved", n, 2);
		op(0, 32'h0028_0400);
		n = 0;
		m = 0;
		for (i = 0; i < 4; i++) begin
			frame_end_in <= 1'b1;
			buffer_done_in <= (i == 1);
			{sav_seen_in, eav_seen_in, ext_timing_lock_in} <= {3{i[0]}};
			tick(1);
			{frame_end_in, buffer_done_in} <= 2'h0;
			tick(2);
			n += (capture_frame_out === 1'b1);
			m += (lstart === 1'b1);
		end
		chk("frames", n, 2);
		chk("lines", m, 2);
		chk("disp buf", 32'(dbuf), 32'h1);
		chk("fill swap", 32'(fill_buf_out), 32'h0);
		{sav_seen_in, eav_seen_in, ext_timing_lock_in} <= 3'h0;
		op(0, 32'h0040_0000);
		tick(TO + 8);
		op(1, 0);
		chk("revert", 32'(q[23:22]), 32'h0);
		op(2, 0);
		chk("absent", 32'(q[9]), 32'h0);
		ven <= 1'b1;
		op(0, 32'h0040_0000);
		tick(48);
		op(2, 0);
		chk("present", 32'(q[9]), 32'h1);
		op(1, 0);
		chk("ext src", 32'(q[23:22]), 32'h1);
		op(0, 0);
		ven <= 1'b0;
		{disp_clk_running_in, disp_timing_gen_in} <= 2'h3;
		tick(4);
		op(0, 32'h0080_0000);
		tick(1);
		chk("oe on", 32'(video_port_clock_pin_oe_out), 32'h1);
		chk("pin drive", 32'(vpo), 32'h1);
		disp_timing_gen_in <= 1'b0;
		tick(3);
		chk("oe off", 32'(video_port_clock_pin_oe_out), 32'h0);
		disp_clk_running_in <= 1'b0;
		tick(4);
		acc(1, 0);
		chk("refused", 32'(got), 32'h0);
		disp_clk_running_in <= 1'b1;
		tick(4);
		op(0, 0);
		conclude();
	end
endmodule
